// ===== logic/angular_phase_timer.sv
// angular phase timer: period/phase measurement, missing pulse, capture/compare, APB registers
`default_nettype none
module angular_phase_timer
  import angular_timer_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  input  wire logic             sysOscTick,
  input  wire logic             fastOscTick,
  input  wire logic             debugHalt,
  input  wire logic [SRC_N-1:0] signalSource,
  input  wire logic [SRC_N-1:0] captureSource,
  output var  logic             phaseClockOut,
  output var  logic             periodClockOut,
  output var  logic             missedPulseOut,
  output var  logic [UNITS-1:0] unitEventOut,
  output var  logic             moduleInterrupt
);

  function automatic logic pick(input logic [SRC_N-1:0] v, input logic [SEL_W-1:0] s);
    return v[s];
  endfunction

  function automatic logic [2:0] psMask(input logic [1:0] ps);
    return 3'((4'h1 << ps) - 4'h1);
  endfunction

  function automatic logic [7:0] unitAddr(input logic [7:0] base, input int y);
    return 8'(base + 8'(y) * UNIT_STEP);
  endfunction

  // bus-side registers
  logic [7:0]       ctrl0_reg, ctrl0_next, ctrl1_reg, ctrl1_next, spHigh_reg, spHigh_next;
  logic [CNT_W-1:0] res_reg, res_next, miss_reg, miss_next, setPoint_reg, setPoint_next;
  logic             clkSel_reg, clkSel_next, pie_reg, pie_next;
  logic [SEL_W-1:0] sigSel_reg, sigSel_next;
  logic [IRQ_N-1:0] ie0_reg, ie0_next, ir0_reg, ir0_next, ie1_reg, ie1_next, ir1_reg, ir1_next;
  logic [31:0]      prdata_next, rd;
  logic             pready_next, pslverr_next, irq_next, mapped;
  logic             setup, wrEn, resWrite;
  // unit registers, one element per unit
  logic [UC_W-1:0]  ucon_reg [UNITS];
  logic [CNT_W-1:0] uval_reg [UNITS];
  logic [SEL_W-1:0] ucsel_reg [UNITS];
  logic [UNITS-1:0] unitEvent;
  // core state
  logic [2:0]       psCnt_reg, psCnt_next;
  logic [SRC_N-1:0] sigS1_reg, sigS2_reg, capS1_reg, capS2_reg;
  logic             sigPrev_reg, sigPrev_next, valid_reg, valid_next, accs_reg, accs_next;
  logic             missSeen_reg, missSeen_next, missEver_reg, missEver_next;
  logic [1:0]       edgeCnt_reg, edgeCnt_next;
  logic [CNT_W-1:0] resDiv_reg, resDiv_next, perCnt_reg, perCnt_next, latched_reg, latched_next;
  logic [CNT_W-1:0] phDiv_reg, phDiv_next, err_reg, err_next, missThr, errCalc;
  logic [PHS_W-1:0] phase_reg, phase_next;
  logic             phOut_next, perOut_next, missOut_next;
  logic             srcTick, tick, sigNow, activeEdge, perTick, phTick, latchNow;
  logic             periodEvent, missHit, overflow, validSet, validClr;
  logic [IRQ_N-1:0] ir0Set;

  // APB phases: answer one cycle after setup
  assign setup    = psel & ~penable;
  assign wrEn     = psel & penable & pready & pwrite;
  assign resWrite = wrEn & (paddr == OFS_RES);

  // register decode, read mux and flag update
  always_comb begin
    ctrl0_next    = ctrl0_reg;
    ctrl1_next    = ctrl1_reg;
    res_next      = res_reg;
    miss_next     = miss_reg;
    spHigh_next   = spHigh_reg;
    setPoint_next = setPoint_reg;
    clkSel_next   = clkSel_reg;
    sigSel_next   = sigSel_reg;
    ie0_next      = ie0_reg;
    ie1_next      = ie1_reg;
    pie_next      = pie_reg;
    mapped        = 1'b1;
    rd            = '0;
    case (paddr)
      OFS_CTRL0: rd = 32'(ctrl0_reg);
      OFS_CTRL1: rd = 32'(ctrl1_reg | 8'((accs_reg << C1_ACCS) | (valid_reg << C1_VALID)));
      OFS_RES:   rd = 32'(res_reg);
      OFS_PER:   rd = 32'(latched_reg);
      OFS_PHS:   rd = 32'(phase_reg);
      OFS_MISS:  rd = 32'(miss_reg);
      OFS_SPL:   rd = 32'(setPoint_reg[7:0]);
      OFS_SPH:   rd = 32'(setPoint_reg[15:8]);
      OFS_ERR:   rd = 32'(err_reg);
      OFS_CLK:   rd = 32'(clkSel_reg);
      OFS_SIG:   rd = 32'(sigSel_reg);
      OFS_IE0:   rd = 32'(ie0_reg);
      OFS_IR0:   rd = 32'(ir0_reg);
      OFS_IE1:   rd = 32'(ie1_reg);
      OFS_IR1:   rd = 32'(ir1_reg);
      OFS_PIE:   rd = 32'({moduleInterrupt, pie_reg});
      default:   mapped = 1'b0;
    endcase
    for (int i = 0; i < UNITS; i++) begin
      if (paddr == unitAddr(OFS_UCON, i)) begin
        rd     = 32'(ucon_reg[i]);
        mapped = 1'b1;
      end
      if (paddr == unitAddr(OFS_UVAL, i)) begin
        rd     = 32'(uval_reg[i]);
        mapped = 1'b1;
      end
      if (paddr == unitAddr(OFS_CSEL, i)) begin
        rd     = 32'(ucsel_reg[i]);
        mapped = 1'b1;
      end
    end
    if (wrEn) begin
      case (paddr)
        OFS_CTRL0: ctrl0_next = pwdata[7:0] & ~8'(1 << (C0_POL - 1));
        OFS_CTRL1: ctrl1_next = pwdata[7:0] & C1_WMASK;
        OFS_RES:   res_next = pwdata[CNT_W-1:0];
        OFS_MISS:  miss_next = pwdata[CNT_W-1:0];
        OFS_SPH:   spHigh_next = pwdata[7:0];
        OFS_SPL:   setPoint_next = {spHigh_reg, pwdata[7:0]};
        OFS_CLK:   clkSel_next = pwdata[0];
        OFS_SIG:   sigSel_next = pwdata[SEL_W-1:0];
        OFS_IE0:   ie0_next = pwdata[IRQ_N-1:0];
        OFS_IE1:   ie1_next = pwdata[IRQ_N-1:0];
        OFS_PIE:   pie_next = pwdata[PIE_EN];
        default:   ;
      endcase
    end
    // write-one-to-clear, a hardware set in the same cycle wins
    ir0_next = (ir0_reg & ~((wrEn && paddr == OFS_IR0) ? pwdata[IRQ_N-1:0] : '0)) | ir0Set;
    ir1_next = (ir1_reg & ~((wrEn && paddr == OFS_IR1) ? pwdata[IRQ_N-1:0] : '0)) | unitEvent;
    irq_next = pie_reg & |((ir0_reg & ie0_reg) | (ir1_reg & ie1_reg));
    pready_next  = setup;
    pslverr_next = setup & ~mapped;
    prdata_next  = setup ? rd : prdata;
  end

  // bus-side register storage
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl0_reg       <= '0;
      ctrl1_reg       <= '0;
      res_reg         <= '0;
      miss_reg        <= '0;
      spHigh_reg      <= '0;
      setPoint_reg    <= '0;
      clkSel_reg      <= '0;
      sigSel_reg      <= '0;
      ie0_reg         <= '0;
      ir0_reg         <= '0;
      ie1_reg         <= '0;
      ir1_reg         <= '0;
      pie_reg         <= '0;
      moduleInterrupt <= '0;
      pready          <= '0;
      pslverr         <= '0;
      prdata          <= '0;
    end else begin
      ctrl0_reg       <= ctrl0_next;
      ctrl1_reg       <= ctrl1_next;
      res_reg         <= res_next;
      miss_reg        <= miss_next;
      spHigh_reg      <= spHigh_next;
      setPoint_reg    <= setPoint_next;
      clkSel_reg      <= clkSel_next;
      sigSel_reg      <= sigSel_next;
      ie0_reg         <= ie0_next;
      ir0_reg         <= ir0_next;
      ie1_reg         <= ie1_next;
      ir1_reg         <= ir1_next;
      pie_reg         <= pie_next;
      moduleInterrupt <= irq_next;
      pready          <= pready_next;
      pslverr         <= pslverr_next;
      prdata          <= prdata_next;
    end
  end

  assign errCalc = {1'b0, perCnt_reg[SP_W-1:0]} - {1'b0, setPoint_reg[SP_W-1:0]};

  // prescaler, period and phase counting, missing pulse and valid tracking
  always_comb begin
    psCnt_next    = '0;
    sigPrev_next  = sigPrev_reg;
    resDiv_next   = resDiv_reg;
    perCnt_next   = perCnt_reg;
    latched_next  = latched_reg;
    phDiv_next    = phDiv_reg;
    phase_next    = phase_reg;
    err_next      = err_reg;
    accs_next     = accs_reg;
    edgeCnt_next  = edgeCnt_reg;
    missSeen_next = missSeen_reg;
    missEver_next = missEver_reg;
    srcTick       = clkSel_reg ? fastOscTick : sysOscTick;
    tick          = 1'b0;
    perTick       = 1'b0;
    phTick        = 1'b0;
    overflow      = 1'b0;
    if (ctrl0_reg[C0_EN]) begin
      psCnt_next = psCnt_reg;
      if (srcTick) begin
        psCnt_next = psCnt_reg + 3'h1;
        tick = (psCnt_reg & psMask(ctrl0_reg[C0_PS +: 2])) == psMask(ctrl0_reg[C0_PS +: 2]);
      end
    end
    sigNow = pick(sigS2_reg, sigSel_reg);
    if (tick) begin
      sigPrev_next = sigNow;
    end
    activeEdge = tick & (ctrl0_reg[C0_POL] ? (sigPrev_reg & ~sigNow) : (~sigPrev_reg & sigNow));
    // resolution divider feeds the period counter
    if (tick) begin
      if (resDiv_reg == res_reg) begin
        resDiv_next = '0;
        perTick     = 1'b1;
      end else begin
        resDiv_next = resDiv_reg + CNT_W'(1);
      end
    end
    if (activeEdge) begin
      perCnt_next = '0;
    end else if (perTick) begin
      perCnt_next = perCnt_reg + CNT_W'(1);
    end
    missThr = ctrl0_reg[C0_ADAPTIVE_MISS_SELECT] ? (latched_reg >> 1) : miss_reg;
    missHit = perTick & ~activeEdge & ((perCnt_reg + CNT_W'(1) - latched_reg) == missThr);
    latchNow    = activeEdge & (~valid_reg | ~ctrl0_reg[C0_MODE] | ~missSeen_reg);
    periodEvent = activeEdge & valid_reg & (~ctrl0_reg[C0_MODE] | missSeen_reg);
    if (activeEdge) begin
      missSeen_next = 1'b0;
    end else if (missHit) begin
      missSeen_next = 1'b1;
    end
    if (missHit) begin
      missEver_next = 1'b1;
    end
    if (latchNow) begin
      latched_next = perCnt_reg;
      accs_next    = perCnt_reg < latched_reg;
      err_next     = errCalc;
    end
    // phase divider: module tick divided by the latched period plus one
    if (periodEvent) begin
      phDiv_next = '0;
    end else if (tick) begin
      if (phDiv_reg == latched_reg) begin
        phDiv_next = '0;
        phTick     = 1'b1;
      end else begin
        phDiv_next = phDiv_reg + CNT_W'(1);
      end
    end
    if (periodEvent) begin
      phase_next = '0;
    end else if (phTick && valid_reg) begin
      if (phase_reg == PHS_MAX) begin
        overflow   = 1'b1;
        phase_next = '0;
      end else begin
        phase_next = phase_reg + PHS_W'(1);
      end
    end
    if (!valid_reg && latchNow && edgeCnt_reg != VALID_EDGE) begin
      edgeCnt_next = edgeCnt_reg + 2'h1;
    end
    validSet = ~valid_reg & latchNow & (edgeCnt_reg == VALID_EDGE) & (perCnt_reg != '0)
             & (~ctrl0_reg[C0_MODE] | missEver_reg);
    validClr = resWrite | overflow | debugHalt | ~ctrl0_reg[C0_EN] | (latched_reg == '0 && valid_reg);
    valid_next = validClr ? 1'b0 : (validSet | valid_reg);
    if (validClr) begin
      edgeCnt_next  = '0;
      missEver_next = 1'b0;
    end
    // outputs gated by valid, then set to their polarity
    phOut_next   = ctrl1_reg[C1_PHP] ^ (phTick & valid_reg);
    perOut_next  = ctrl1_reg[C1_PRP] ^ periodEvent;
    missOut_next = ctrl1_reg[C1_MPP] ^ (missHit & valid_reg);
    ir0Set = '0;
    ir0Set[IR0_PER]  = periodEvent;
    ir0Set[IR0_PHS]  = phTick & valid_reg;
    ir0Set[IR0_MISS] = missHit & valid_reg;
  end

  // core storage and input synchronisers
  always_ff @(posedge clock) begin
    sigS1_reg <= signalSource;
    sigS2_reg <= sigS1_reg;
    capS1_reg <= captureSource;
    capS2_reg <= capS1_reg;
    if (rst) begin
      psCnt_reg      <= '0;
      sigPrev_reg    <= '0;
      resDiv_reg     <= '0;
      perCnt_reg     <= '0;
      latched_reg    <= '0;
      phDiv_reg      <= '0;
      phase_reg      <= '0;
      err_reg        <= '0;
      accs_reg       <= '0;
      edgeCnt_reg    <= '0;
      missSeen_reg   <= '0;
      missEver_reg   <= '0;
      valid_reg      <= '0;
      phaseClockOut  <= '0;
      periodClockOut <= '0;
      missedPulseOut <= '0;
    end else begin
      psCnt_reg      <= psCnt_next;
      sigPrev_reg    <= sigPrev_next;
      resDiv_reg     <= resDiv_next;
      perCnt_reg     <= perCnt_next;
      latched_reg    <= latched_next;
      phDiv_reg      <= phDiv_next;
      phase_reg      <= phase_next;
      err_reg        <= err_next;
      accs_reg       <= accs_next;
      edgeCnt_reg    <= edgeCnt_next;
      missSeen_reg   <= missSeen_next;
      missEver_reg   <= missEver_next;
      valid_reg      <= valid_next;
      phaseClockOut  <= phOut_next;
      periodClockOut <= perOut_next;
      missedPulseOut <= missOut_next;
    end
  end

  // capture/compare units
  for (genvar y = 0; y < UNITS; y++) begin : g_unit
    logic [UC_W-1:0]  con_next;
    logic [CNT_W-1:0] val_next;
    logic [SEL_W-1:0] sel_next;
    logic             capPrev_reg, capPrev_next, matchPrev_reg, matchPrev_next, out_next;
    logic             capIn, match, ev;

    // edge detect on the module tick, event gated by valid
    always_comb begin
      con_next       = ucon_reg[y];
      val_next       = uval_reg[y];
      sel_next       = ucsel_reg[y];
      capPrev_next   = capPrev_reg;
      matchPrev_next = matchPrev_reg;
      capIn = pick(capS2_reg, ucsel_reg[y]) ^ ucon_reg[y][UC_CAPP];
      match = uval_reg[y] == CNT_W'(phase_reg);
      if (tick) begin
        capPrev_next   = capIn;
        matchPrev_next = match;
      end
      ev = tick & valid_reg & (ucon_reg[y][UC_MODE] ? (capIn & ~capPrev_reg)
                                                   : (match & ~matchPrev_reg));
      if (wrEn && paddr == unitAddr(OFS_UCON, y)) begin
        con_next = pwdata[UC_W-1:0];
      end
      if (wrEn && paddr == unitAddr(OFS_CSEL, y)) begin
        sel_next = pwdata[SEL_W-1:0];
      end
      if (ev && ucon_reg[y][UC_MODE]) begin
        val_next = CNT_W'(phase_reg);
      end else if (wrEn && paddr == unitAddr(OFS_UVAL, y) && !ucon_reg[y][UC_MODE]) begin
        val_next = pwdata[CNT_W-1:0];
      end
      out_next = ucon_reg[y][UC_POL] ^ ev;
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        ucon_reg[y]     <= '0;
        uval_reg[y]     <= '0;
        ucsel_reg[y]    <= '0;
        capPrev_reg     <= '0;
        matchPrev_reg   <= '0;
        unitEventOut[y] <= '0;
      end else begin
        ucon_reg[y]     <= con_next;
        uval_reg[y]     <= val_next;
        ucsel_reg[y]    <= sel_next;
        capPrev_reg     <= capPrev_next;
        matchPrev_reg   <= matchPrev_next;
        unitEventOut[y] <= out_next;
      end
    end

    assign unitEvent[y] = ev;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_invalid_quiet;
    !valid_reg |=> phaseClockOut == $past(ctrl1_reg[C1_PHP]) && periodClockOut == $past(ctrl1_reg[C1_PRP])
                   && missedPulseOut == $past(ctrl1_reg[C1_MPP]);
  endproperty
  a_invalid_quiet: assert property (p_invalid_quiet) else $error("output active while invalid");
  property p_phase_hold;
    !valid_reg ##1 !valid_reg |-> $stable(phase_reg);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase moved while invalid");
  property p_latch_invalid;
    !valid_reg && activeEdge |=> latched_reg == $past(perCnt_reg);
  endproperty
  a_latch_invalid: assert property (p_latch_invalid) else $error("edge did not latch period");
  property p_res_clear;
    resWrite |=> !valid_reg;
  endproperty
  a_res_clear: assert property (p_res_clear) else $error("valid survived resolution write");
  property p_disable_clear;
    !ctrl0_reg[C0_EN] |=> !valid_reg ##1 !ctrl0_reg[C0_EN] [*1] |-> !valid_reg;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("valid set while disabled");
  property p_error;
    latchNow |=> err_reg == $past(errCalc) && latched_reg == $past(perCnt_reg);
  endproperty
  a_error: assert property (p_error) else $error("error pair wrong");
  property p_set_point;
    wrEn && paddr == OFS_SPH |=> $stable(setPoint_reg);
  endproperty
  a_set_point: assert property (p_set_point) else $error("set point changed on high write");
  property p_irq;
    pie_reg && |(ir0_reg & ie0_reg) |=> moduleInterrupt;
  endproperty
  a_irq: assert property (p_irq) else $error("module flag missing");
  property p_irq_gate;
    !pie_reg |=> !moduleInterrupt;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("module flag without enable");
  property p_period_flag;
    periodEvent |=> ir0_reg[IR0_PER] && periodClockOut != $past(ctrl1_reg[C1_PRP]);
  endproperty
  a_period_flag: assert property (p_period_flag) else $error("period flag or output missing");
  property p_valid_edges;
    $rose(valid_reg) |-> $past(edgeCnt_reg) == VALID_EDGE;
  endproperty
  a_valid_edges: assert property (p_valid_edges) else $error("valid set too early");

  c_valid: cover property ($rose(valid_reg));
  c_period: cover property (periodEvent);
  c_miss: cover property (missHit && valid_reg);
  c_unit: cover property (|unitEvent);
endmodule
`default_nettype wire

// ===== logic/angular_timer_pkg.sv
// constants, register offsets and field positions of the angular phase timer
`default_nettype none
package angular_timer_pkg;
  localparam int CNT_W = 16;                 // period, resolution, threshold and value pairs
  localparam int PHS_W = 10;                 // phase counter width
  localparam int SP_W  = 15;                 // unsigned set point and period operand width
  localparam int UNITS = 3;                  // capture/compare units
  localparam int SRC_N = 4;                  // selectable input and capture sources
  localparam int SEL_W = 2;                  // source select field width
  localparam int IRQ_N = 3;                  // sources per flag register
  localparam logic [PHS_W-1:0] PHS_MAX    = 10'h3FF;
  localparam logic [1:0]       VALID_EDGE = 2'h2;   // latching edges seen before the third
  localparam logic [7:0]       UNIT_STEP  = 8'h04;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES   = 8'h08;
  localparam logic [7:0] OFS_PER   = 8'h0C;
  localparam logic [7:0] OFS_PHS   = 8'h10;
  localparam logic [7:0] OFS_MISS  = 8'h14;
  localparam logic [7:0] OFS_SPL   = 8'h18;
  localparam logic [7:0] OFS_SPH   = 8'h1C;
  localparam logic [7:0] OFS_ERR   = 8'h20;
  localparam logic [7:0] OFS_CLK   = 8'h24;
  localparam logic [7:0] OFS_SIG   = 8'h28;
  localparam logic [7:0] OFS_IE0   = 8'h2C;
  localparam logic [7:0] OFS_IR0   = 8'h30;
  localparam logic [7:0] OFS_IE1   = 8'h34;
  localparam logic [7:0] OFS_IR1   = 8'h38;
  localparam logic [7:0] OFS_PIE   = 8'h3C;
  localparam logic [7:0] OFS_UCON  = 8'h40;
  localparam logic [7:0] OFS_UVAL  = 8'h50;
  localparam logic [7:0] OFS_CSEL  = 8'h60;
  // control_zero fields
  localparam int C0_EN    = 7;
  localparam int C0_PS    = 4;
  localparam int C0_POL   = 3;
  localparam int C0_ADAPTIVE_MISS_SELECT = 1;
  localparam int C0_MODE  = 0;
  // control_one fields
  localparam int C1_PHP   = 6;
  localparam int C1_PRP   = 4;
  localparam int C1_MPP   = 2;
  localparam int C1_ACCS  = 1;
  localparam int C1_VALID = 0;
  localparam logic [7:0] C1_WMASK = 8'h54;
  // flag and enable bit positions
  localparam int IR0_PER  = 0;
  localparam int IR0_PHS  = 1;
  localparam int IR0_MISS = 2;
  localparam int PIE_EN   = 0;
  localparam int PIE_FLAG = 1;
  // unit_control fields
  localparam int UC_MODE  = 0;
  localparam int UC_POL   = 1;
  localparam int UC_CAPP  = 2;
  localparam int UC_W     = 3;
endpackage
`default_nettype wire

// ===== testbench/pulse_source.sv
// periodic sensor pulse model for the measured input
`default_nettype none
module pulse_source (
  input  wire logic        clock,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output var  logic        pulseOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0000;
  // one four-cycle high pulse per period, low while stopped
  always @(posedge clock) begin
    cnt <= (!run || cnt >= period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
    pulseOut <= run && cnt < 16'h0004;
  end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the angular phase timer
`default_nettype none
module testbench import angular_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        run = 1'b0;
  logic        sawOut = 1'b0;
  logic        sawUnit = 1'b0;
  logic        halt = 1'b0;
  logic [3:0]  cap = 4'h0;
  logic        pulse, pready, pslverr, serr, phsOut, perOut, missOut, irq;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [2:0]  unitEv;
  int          errTotal = 0;
  int          checksDone = 0;
  int          cycles = 0;

  always #2 clock = ~clock;
  pulse_source pulse_source_inst (.clock(clock), .run(run), .period(16'h00C8), .pulseOut(pulse));
  angular_phase_timer angular_phase_timer_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysOscTick(1'b0), .fastOscTick(1'b1), .debugHalt(halt),
    .signalSource({2'h0, pulse, 1'b0}), .captureSource(cap), .phaseClockOut(phsOut),
    .periodClockOut(perOut), .missedPulseOut(missOut), .unitEventOut(unitEv), .moduleInterrupt(irq));

  task automatic wrapUp();
    $display("errors %0d checks %0d", errTotal, checksDone);
    if (errTotal == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one bus transfer: setup, access held until pready, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd, 32'h0, "ctrl1 reset");
    apb(1'b1, 8'hFC, 32'hFF);
    chk({31'h0, serr}, 32'h1, "unmapped");
  endtask

  task automatic t_valid();
    apb(1'b1, OFS_SIG, 32'h1);
    apb(1'b1, OFS_CLK, 32'h1);
    apb(1'b1, OFS_RES, 32'h3);
    apb(1'b1, OFS_CTRL0, 32'h80);
    sawOut = 1'b0;
    run <= 1'b1;
    cyc(390);
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd & 32'h1, 32'h0, "valid early");
    chk({31'h0, sawOut}, 32'h0, "output while invalid");
    apb(1'b0, OFS_PHS, 32'h0);
    chk(rd, 32'h0, "phase held");
    cyc(30);
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd & 32'h1, 32'h1, "valid third edge");
  endtask

  task automatic t_error();
    logic [31:0] per;
    apb(1'b1, OFS_SPH, 32'h0);
    apb(1'b1, OFS_SPL, 32'h10);
    cyc(200);
    apb(1'b0, OFS_PER, 32'h0);
    per = rd;
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd & 32'hFFFF, {16'h0, 16'(per[14:0]) - 16'h0010}, "error");
    apb(1'b1, OFS_SPH, 32'h1);
    cyc(200);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd & 32'hFFFF, {16'h0, 16'(per[14:0]) - 16'h0010}, "high alone");
    apb(1'b1, OFS_SPL, 32'h0);
    cyc(200);
    apb(1'b0, OFS_ERR, 32'h0);
    chk(rd & 32'hFFFF, {16'h0, 16'(per[14:0]) - 16'h0100}, "both bytes");
  endtask

  task automatic t_irq();
    apb(1'b1, OFS_IE0, 32'h1);
    apb(1'b1, OFS_PIE, 32'h1);
    cyc(200);
    chk({31'h0, irq}, 32'h1, "module flag");
    apb(1'b0, OFS_IR0, 32'h0);
    chk(rd & 32'h1, 32'h1, "period flag");
    chk(rd & 32'h4, 32'h4, "miss at threshold");
    apb(1'b1, OFS_IE0, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "source off");
    apb(1'b1, OFS_IR0, 32'h7);
    apb(1'b0, OFS_IR0, 32'h0);
    chk(rd & 32'h1, 32'h0, "flag cleared");
    apb(1'b1, OFS_MISS, 32'h100);
    apb(1'b1, OFS_IR0, 32'h7);
    cyc(200);
    apb(1'b0, OFS_IR0, 32'h0);
    chk(rd & 32'h5, 32'h1, "threshold out of reach");
  endtask

  // compare match, capture event, locked capture value, halt
  task automatic t_unit();
    apb(1'b1, OFS_UVAL, 32'h200);
    apb(1'b1, OFS_IR1, 32'h7);
    sawUnit = 1'b0;
    cyc(200);
    apb(1'b0, OFS_IR1, 32'h0);
    chk(rd & 32'h1, 32'h0, "no match");
    chk({31'h0, sawUnit}, 32'h0, "no unit output");
    apb(1'b1, OFS_UVAL, 32'h2);
    apb(1'b1, OFS_UCON + 8'h04, 32'h1);
    apb(1'b1, OFS_CSEL + 8'h04, 32'h1);
    apb(1'b1, OFS_IR1, 32'h7);
    cap <= 4'h2;
    cyc(200);
    apb(1'b0, OFS_IR1, 32'h0);
    chk(rd & 32'h3, 32'h3, "unit events");
    chk({31'h0, sawUnit}, 32'h1, "unit output");
    apb(1'b1, OFS_UVAL + 8'h04, 32'hFFFF);
    apb(1'b0, OFS_UVAL + 8'h04, 32'h0);
    chk({31'h0, rd == 32'hFFFF}, 32'h0, "capture value locked");
    halt <= 1'b1;
    cyc(1);
    halt <= 1'b0;
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd & 32'h1, 32'h0, "halt clears valid");
    cyc(620);
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd & 32'h1, 32'h1, "valid again");
  endtask

  task automatic t_pol();
    apb(1'b1, OFS_RES, 32'h3);
    apb(1'b1, OFS_CTRL1, 32'h54);
    apb(1'b1, OFS_UCON + 8'h08, 32'h2);
    cyc(2);
    chk({28'h0, unitEv[2], phsOut, perOut, missOut}, 32'hF, "inverted idle");
    apb(1'b0, OFS_CTRL1, 32'h0);
    chk(rd & 32'h1, 32'h0, "res write");
    apb(1'b1, OFS_CTRL0, 32'h90);
    cyc(420);
    apb(1'b0, OFS_PER, 32'h0);
    chk({31'h0, rd >= 32'h18 && rd <= 32'h19}, 32'h1, "prescale");
  endtask

  // main sequence
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(3);
    t_reset();
    t_valid();
    t_error();
    t_irq();
    t_unit();
    t_pol();
    wrapUp();
  end

  // output watch and hang limit
  always @(posedge clock) begin
    cycles++;
    if (perOut | phsOut | missOut) sawOut <= 1'b1;
    if (unitEv[0]) sawUnit <= 1'b1;
    if (cycles == 5000) begin
      errTotal++;
      wrapUp();
    end
  end
endmodule
`default_nettype wire
